/* hdl/ufrc_pkg.sv */
package ufrc_pkg;
  localparam logic [7:0] UFRC_ADDR_GLYPH = 8'h05;
  localparam logic [7:0] UFRC_ADDR_CURSOR = 8'h0F;
  localparam logic [7:0] UFRC_PTR_FIRST = 8'h80;
  localparam logic [7:0] UFRC_PTR_LASTINC = 8'hF6;
  localparam logic [7:0] UFRC_PTR_FINAL = 8'hF7;
  localparam logic [7:0] UFRC_CURSOR_RESET = 8'h00;
  localparam int UFRC_PTR_BIT = 7;
  localparam int UFRC_BLINK_BIT = 7;
  localparam int UFRC_GLYPHS = 24;
  localparam int UFRC_COLS = 5;
  localparam int UFRC_ENTRIES = UFRC_GLYPHS * UFRC_COLS;
  localparam int UFRC_OSC_HZ = 4000000;
  localparam int UFRC_HALF_SLOW_MS = 1000;
  localparam int UFRC_HALF_FAST_MS = 500;
endpackage : ufrc_pkg

/* hdl/ufrc_glyph_cursor.sv */
// Functional notes
// - Glyph port read returns 7-bit entry at current pointer.
// - Read-back byte has its top bit forced to zero.
// - Pointer advances after every glyph read below 0xF7.
// - Writes 0x00-0x7F store low seven bits at the pointer.
// - Pointer advances after every glyph write below 0xF7.
// - Writes with bit 7 set load the pointer, store nothing.
// - Pointer 0x80-0xF7 accepted; auto-increment works inside that range.
// - After access at 0xF7 further glyph data accesses are ignored until a pointer write.
// - Pointer writes 0xF8-0xFF become 0x80.
// - Twenty-four glyphs, glyph n based at 0x80 plus 5n.
// - Cursor register: position in bits 6..0, blink flag bit 7.
// - Blinking cursor lit only in first half of blink period.
// - Position code is digit minus one; bits 6,5 both set lights none.
// - Blink clock low first half, high second half, equal halves.
// - Rate bit clear gives 1 s halves, set gives 0.5 s halves.
`timescale 1ns/1ps
`default_nettype none
module ufrc_glyph_cursor #(
  parameter int OSC_HZ = ufrc_pkg::UFRC_OSC_HZ,
  parameter int HALF_SLOW_CYC = OSC_HZ / 1000 * ufrc_pkg::UFRC_HALF_SLOW_MS,
  parameter int HALF_FAST_CYC = OSC_HZ / 1000 * ufrc_pkg::UFRC_HALF_FAST_MS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic blink_fast,
  input wire logic [6:0] glyph_rd_index,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic [7:0] glyph_ptr,
  output logic glyph_locked,
  output logic [6:0] glyph_col,
  output logic blink_clk,
  output logic cursor_on,
  output logic [6:0] cursor_pos
);
  localparam int ENT = ufrc_pkg::UFRC_ENTRIES;

  logic [6:0] mem [ENT];
  logic [7:0] ptr_ff, nxt_ptr;
  logic lock_ff, nxt_lock;
  logic [7:0] cur_ff, nxt_cur;
  logic [7:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic [6:0] col_ff, nxt_col;
  logic [31:0] bcnt_ff, nxt_bcnt;
  logic blink_ff, nxt_blink;
  logic con_ff, nxt_con;
  logic glyph_hit, data_acc, mem_we;
  logic [6:0] idx;
  logic [31:0] half_cyc;

  assign glyph_hit = reg_addr == ufrc_pkg::UFRC_ADDR_GLYPH;
  assign idx = 7'(ptr_ff - ufrc_pkg::UFRC_PTR_FIRST);
  // Data access only when not locked and not a pointer write
  assign data_acc = glyph_hit && !lock_ff &&
    (reg_rd || (reg_wr && !reg_wdata[ufrc_pkg::UFRC_PTR_BIT]));
  assign mem_we = clk_en && data_acc && reg_wr;
  assign half_cyc = blink_fast ? 32'(HALF_FAST_CYC) : 32'(HALF_SLOW_CYC);

  always_comb begin
    nxt_ptr = ptr_ff;
    nxt_lock = lock_ff;
    nxt_cur = cur_ff;
    nxt_rdata = rdata_ff;
    nxt_rvalid = 1'b0;
    if (reg_wr && glyph_hit && reg_wdata[ufrc_pkg::UFRC_PTR_BIT]) begin
      nxt_lock = 1'b0;
      if (reg_wdata > ufrc_pkg::UFRC_PTR_FINAL) begin
        nxt_ptr = ufrc_pkg::UFRC_PTR_FIRST;
      end else begin
        nxt_ptr = reg_wdata;
      end
    end else if (data_acc) begin
      if (ptr_ff == ufrc_pkg::UFRC_PTR_FINAL) begin
        nxt_lock = 1'b1;
      end else begin
        nxt_ptr = ptr_ff + 8'h01;
      end
    end else if (reg_wr && reg_addr == ufrc_pkg::UFRC_ADDR_CURSOR) begin
      nxt_cur = reg_wdata;
    end
    if (reg_rd) begin
      nxt_rvalid = 1'b1;
      if (glyph_hit) begin
        // Locked port still answers, with zero
        nxt_rdata = lock_ff ? 8'h00 : {1'b0, mem[idx]};
      end else if (reg_addr == ufrc_pkg::UFRC_ADDR_CURSOR) begin
        nxt_rdata = cur_ff;
      end else begin
        nxt_rdata = 8'h00;
      end
    end
  end

  always_comb begin
    nxt_col = mem[glyph_rd_index < 7'(ENT) ? glyph_rd_index : 7'h00];
    if (bcnt_ff + 32'h1 >= half_cyc) begin
      nxt_bcnt = 32'h0;
      nxt_blink = ~blink_ff;
    end else begin
      nxt_bcnt = bcnt_ff + 32'h1;
      nxt_blink = blink_ff;
    end
    if (cur_ff[6] && cur_ff[5]) begin
      nxt_con = 1'b0;
    end else if (cur_ff[ufrc_pkg::UFRC_BLINK_BIT]) begin
      nxt_con = ~nxt_blink;
    end else begin
      nxt_con = 1'b1;
    end
  end

  // Glyph store has no reset; contents after power-up are undefined
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[idx] <= reg_wdata[6:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_ff <= ufrc_pkg::UFRC_PTR_FIRST;
      lock_ff <= 1'b0;
      cur_ff <= ufrc_pkg::UFRC_CURSOR_RESET;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
      col_ff <= 7'h00;
      bcnt_ff <= 32'h0;
      blink_ff <= 1'b0;
      con_ff <= 1'b0;
    end else if (clk_en) begin
      ptr_ff <= nxt_ptr;
      lock_ff <= nxt_lock;
      cur_ff <= nxt_cur;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      col_ff <= nxt_col;
      bcnt_ff <= nxt_bcnt;
      blink_ff <= nxt_blink;
      con_ff <= nxt_con;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign glyph_ptr = ptr_ff;
  assign glyph_locked = lock_ff;
  assign glyph_col = col_ff;
  assign blink_clk = blink_ff;
  assign cursor_on = con_ff;
  assign cursor_pos = cur_ff[6:0];

  a_rd_msb_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    rvalid_ff |-> !(rdata_ff[7] && $past(glyph_hit))) else $error("glyph read msb set");
  a_ptr_advance: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && data_acc && ptr_ff != ufrc_pkg::UFRC_PTR_FINAL |=> ptr_ff == $past(ptr_ff) + 8'h01)
    else $error("pointer did not advance");
  a_ptr_load: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && reg_wr && glyph_hit && reg_wdata[7] && reg_wdata <= ufrc_pkg::UFRC_PTR_FINAL
    |=> ptr_ff == $past(reg_wdata) && !lock_ff) else $error("pointer load wrong");
  a_ptr_clamp: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && reg_wr && glyph_hit && reg_wdata > ufrc_pkg::UFRC_PTR_FINAL
    |=> ptr_ff == ufrc_pkg::UFRC_PTR_FIRST) else $error("pointer not clamped");
  a_lock_set: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && data_acc && ptr_ff == ufrc_pkg::UFRC_PTR_FINAL |=> lock_ff && $stable(ptr_ff))
    else $error("lock not set");
  a_lock_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    lock_ff && !(reg_wr && glyph_hit && reg_wdata[7]) |=> lock_ff) else $error("lock dropped");
  a_ptr_range: assert property (@(posedge mclk) disable iff (!rst_n)
    ptr_ff >= ufrc_pkg::UFRC_PTR_FIRST && ptr_ff <= ufrc_pkg::UFRC_PTR_FINAL)
    else $error("pointer out of range");
  a_no_cursor: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && cur_ff[6] && cur_ff[5] |=> !cursor_on) else $error("hidden cursor lit");
  a_blink_half: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && !cur_ff[6] && cur_ff[7] && $stable(cur_ff) |=> cursor_on == !blink_ff)
    else $error("blink phase wrong");

  // Clock enable low must freeze the pointer, lock and cursor registers
  a_freeze_state: assert property (@(posedge mclk) disable iff (!rst_n)
    !clk_en |=> $stable(ptr_ff) && $stable(lock_ff) && $stable(cur_ff))
    else $error("state moved while frozen");
  // Idle bus leaves pointer and lock alone
  a_ptr_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && !reg_wr && !reg_rd |=> $stable(ptr_ff) && $stable(lock_ff))
    else $error("pointer moved while idle");
  // Every taken read gets exactly one answer pulse
  a_rvalid_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && reg_rd |=> rvalid_ff)
    else $error("read not answered");
  // No answer without a read
  a_rvalid_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && !reg_rd |=> !rvalid_ff)
    else $error("spurious read answer");
  // Locked port still answers, but only with zero
  a_locked_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && reg_rd && glyph_hit && lock_ff |=> rdata_ff == 8'h00)
    else $error("locked read not zero");
  // Locked pointer stays put until a pointer write
  a_lock_still: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && lock_ff && !(reg_wr && glyph_hit && reg_wdata[ufrc_pkg::UFRC_PTR_BIT]) |=> $stable(ptr_ff))
    else $error("locked pointer moved");
  // Cursor byte is kept whole, blink flag included
  a_cur_load: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && reg_wr && reg_addr == ufrc_pkg::UFRC_ADDR_CURSOR |=> cur_ff == $past(reg_wdata))
    else $error("cursor write lost");
  // Steady cursor must be lit whatever the blink phase
  a_cur_steady: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && !cur_ff[ufrc_pkg::UFRC_BLINK_BIT] && !(cur_ff[6] && cur_ff[5]) |=> cursor_on)
    else $error("steady cursor dark");
  // Blink clock flips once per half period
  a_blink_flip: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && bcnt_ff + 32'h1 >= half_cyc |=> blink_ff != $past(blink_ff))
    else $error("blink clock did not flip");
  // Inside a half the blink clock holds, so halves stay equal
  a_blink_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && bcnt_ff + 32'h1 < half_cyc |=> $stable(blink_ff))
    else $error("blink clock flipped early");
endmodule : ufrc_glyph_cursor
`default_nettype wire

/* verification/ufrc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ufrc_host (
  input wire logic mclk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // One strobe per byte; idle bus shows inverted data, not the stale byte
  task acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_wdata <= ~d;
    // Return off the edge so callers see the settled result
    @(negedge mclk);
  endtask : acc
  task glyph(input logic [7:0] base, input logic [7:0] c [5]);
    acc(1'b1, 8'h05, base);
    for (int i = 0; i < 5; i++) acc(1'b1, 8'h05, c[i]);
  endtask : glyph
endmodule : ufrc_host
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic blink_fast = 1'b0;
  logic clk_en = 1'b1;
  logic [6:0] glyph_rd_index = 7'h00;
  logic reg_wr, reg_rd, reg_rvalid, glyph_locked, blink_clk, cursor_on;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, glyph_ptr;
  logic [6:0] glyph_col, cursor_pos;
  int errors = 0;
  int n_tests = 0;
  logic [7:0] exp_q [$];
  always #2.5 mclk = ~mclk;
  ufrc_host host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  ufrc_glyph_cursor #(.HALF_SLOW_CYC(8), .HALF_FAST_CYC(4)) dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .blink_fast(blink_fast),
    .glyph_rd_index(glyph_rd_index), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .glyph_ptr(glyph_ptr),
    .glyph_locked(glyph_locked), .glyph_col(glyph_col), .blink_clk(blink_clk), .cursor_on(cursor_on),
    .cursor_pos(cursor_pos));
  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task summarize;
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task rd(input logic [7:0] e);
    exp_q.push_back(e);
    host.acc(1'b0, 8'h05, 8'($urandom));
  endtask : rd
  always @(posedge mclk) if (reg_rvalid === 1'b1) chk("rdata", exp_q.size() ? exp_q.pop_front() : 8'hXX, reg_rdata);
  initial begin
    logic [7:0] c [5];
    int hi;
    void'($urandom(3));
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) c[i] = 8'($urandom_range(0, 127));
    host.glyph(8'h8A, c);
    chk("ptr", 8'h8F, glyph_ptr);
    @(posedge mclk);
    glyph_rd_index <= 7'h0A;
    repeat (2) @(posedge mclk);
    chk("col", {1'b0, c[0][6:0]}, {1'b0, glyph_col});
    host.acc(1'b1, 8'h05, 8'h8A);
    for (int i = 0; i < 5; i++) rd({1'b0, c[i][6:0]});
    chk("ptr", 8'h8F, glyph_ptr);
    @(posedge mclk);
    clk_en <= 1'b0;
    host.acc(1'b1, 8'h05, 8'h90);
    chk("freeze", 8'h8F, glyph_ptr);
    @(posedge mclk);
    clk_en <= 1'b1;
    for (int p = 8'hF8; p <= 8'hFF; p++) begin
      host.acc(1'b1, 8'h05, 8'(p));
      chk("ptr", 8'h80, glyph_ptr);
    end
    host.acc(1'b1, 8'h05, 8'hF6);
    chk("ptr", 8'hF6, glyph_ptr);
    host.acc(1'b1, 8'h05, 8'h11);
    host.acc(1'b1, 8'h05, 8'h22);
    chk("lock", 8'h01, {7'h00, glyph_locked});
    rd(8'h00);
    host.acc(1'b1, 8'h05, 8'h33);
    chk("ptr", 8'hF7, glyph_ptr);
    host.acc(1'b1, 8'h05, 8'hF6);
    chk("lock", 8'h00, {7'h00, glyph_locked});
    rd(8'h11);
    rd(8'h22);
    host.acc(1'b1, 8'h0F, 8'h5F);
    @(posedge mclk);
    chk("cur", 8'hDF, {cursor_on, cursor_pos});
    host.acc(1'b1, 8'h0F, 8'hE0);
    @(posedge mclk);
    hi = 0;
    repeat (20) @(posedge mclk) hi += cursor_on;
    chk("nocur", 8'h00, 8'(hi));
    host.acc(1'b1, 8'h0F, 8'h80);
    exp_q.push_back(8'h80);
    host.acc(1'b0, 8'h0F, 8'h00);
    for (int f = 0; f < 2; f++) begin
      @(posedge mclk);
      blink_fast <= f[0];
      repeat (40) @(posedge mclk);
      hi = 0;
      for (int k = 0; k < 32; k++) begin
        @(posedge mclk);
        hi += blink_clk;
        chk("blink", {7'h00, !blink_clk}, {7'h00, cursor_on});
      end
      chk("half", 8'h10, 8'(hi));
    end
    chk("pending", 8'h00, 8'(exp_q.size()));
    summarize();
  end
endmodule : tb_top
`default_nettype wire
